// File: core/dcx_channel.v
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "dcx_regs.vh"

// Operation
// - write matched sector from memory
// - bump sector number per sector
// - short range: zero fill
// - long range: next sector
// - two index marks: unsuccessful
// - id error: read error, search on
// - later hit: clear error, recovery
// - residual range kept
// - zero range: end at once
// - diag write: memory check bytes
// - diag read: check bytes out
// - task bit picks wrap buffer
// - wrap write: memory to buffer
// - wrap read returns those bytes
// - bad wrap range: end, flag
// - initialize loads error log
// - control orders any time, abort only while busy
// - initialize: power-up, recal
// - abort: stop, irq, keep state
// - address order: low 16 bits
// - module order: high 4 bits
// - range order returns range
module dcx_channel #(
   parameter [15:0] ELOG_CYL = `DCX_ELOG_CYL,
   parameter [15:0] WRAP_MAX = `DCX_WRAP_MAX
) (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite slave
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // completion interrupt
   output reg         irq_reg,
   // memory byte port
   output reg         mem_req_reg,
   output reg         mem_we_reg,
   output reg  [20:0] mem_addr_reg,
   output reg  [7:0]  mem_wdata_reg,
   input  wire [7:0]  mem_rdata,
   input  wire        mem_ack,
   // disk drive side
   input  wire        disk_index,
   input  wire        disk_id_tgl,
   input  wire        disk_id_crc_err,
   input  wire [31:0] disk_id,
   input  wire        disk_byte_tgl,
   input  wire [7:0]  disk_rd_byte,
   output reg         disk_wr_gate_reg,
   output reg         disk_rd_gate_reg,
   output reg         disk_check_gen_reg,
   output reg  [7:0]  disk_wr_byte_reg,
   output reg         disk_recal_reg
);

   // one-hot states
   localparam [5:0] S_IDLE = 6'b00_0001;
   localparam [5:0] S_SRCH = 6'b00_0010;
   localparam [5:0] S_XFER = 6'b00_0100;
   localparam [5:0] S_WRPW = 6'b00_1000;
   localparam [5:0] S_WRPR = 6'b01_0000;
   localparam [5:0] S_DONE = 6'b10_0000;

   // register file and working state
   reg  [15:0] task_reg;
   reg  [15:0] cfga_reg;
   reg  [15:0] cfgb_reg;
   reg  [20:0] addr_reg;
   reg  [15:0] range_reg;
   reg  [15:0] st1_reg;
   reg  [15:0] st2_reg;
   reg  [5:0]  ilvl_reg;
   reg  [8:0]  eptr_reg;
   reg  [5:0]  state_reg;
   reg  [8:0]  cnt_reg;
   reg         idx_reg;
   reg         herr_reg;
   reg  [7:0]  buf_reg;
   reg         have_reg;
   reg  [12:0] wlen_reg;
   reg  [12:0] wptr_reg;
   reg         elog_reg;
   reg         esec_reg;
   reg  [7:0]  elog_mem [0:511];
   reg  [7:0]  wbuf_a [0:4095];
   reg  [7:0]  wbuf_b [0:4095];

   // input synchronisers, stage 1 read only by stage 2
   reg  [43:0] sy1_reg;
   reg  [43:0] sy2_reg;
   reg  [2:0]  sy3_reg;

   // id compare for both searches
   function dcx_match;
      input [31:0] id;
      input [31:0] tgt;
      begin
         dcx_match = (id == tgt);
      end
   endfunction

   wire [7:0]  cmd      = {4'h0, task_reg[15:12]};
   wire        rd_mode  = elog_reg | (cmd[3:0] == `DCX_CMD_DRD);
   wire        diag     = (cmd[3:0] == `DCX_CMD_DWR) | (cmd[3:0] == `DCX_CMD_DRD);
   wire [8:0]  last_b   = diag ? (`DCX_DIAG_LEN - 9'h001) : (`DCX_SECT_LEN - 9'h001);
   wire [31:0] tgt      = elog_reg ? {ELOG_CYL, 8'h00, 7'h00, esec_reg}
                                   : {cfga_reg, cfgb_reg};
   wire        idx_ev   = sy2_reg[0] & ~sy3_reg[0];
   wire        id_ev    = sy2_reg[1] ^ sy3_reg[1];
   wire        byte_ev  = sy2_reg[43] ^ sy3_reg[2];
   wire        id_crc   = sy2_reg[2];
   wire [31:0] id_val   = sy2_reg[34:3];
   wire [7:0]  rd_byte  = sy2_reg[42:35];
   wire [7:0]  wrap_rd  = task_reg[0] ? wbuf_a[wptr_reg[11:0]]
                                      : wbuf_b[wptr_reg[11:0]];
   wire        wr_en    = s_axi_awready;
   wire [7:0]  wa       = s_axi_awaddr;
   wire [31:0] wd       = s_axi_wdata;
   wire        ctl_wr   = wr_en & (wa == `DCX_CTRL) & s_axi_wstrb[0];
   wire        do_init  = ctl_wr & wd[`DCX_CTRL_INIT];
   wire        do_abort = ctl_wr & wd[`DCX_CTRL_ABORT] & ~state_reg[0];
   wire        idle     = state_reg[0];
   wire        wr_go    = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
   wire        rd_go    = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
   wire        wa_ok    = (wa[1:0] == 2'b00) & (wa <= `DCX_STATE);

   // two-flop pin capture, third stage for edges
   always @(posedge aclk) begin
      if (!aresetn) begin
         sy1_reg <= 44'h000_0000_0000;
         sy2_reg <= 44'h000_0000_0000;
         sy3_reg <= 3'b000;
      end else begin
         sy1_reg <= {disk_byte_tgl, disk_rd_byte, disk_id, disk_id_crc_err,
                     disk_id_tgl, disk_index};
         sy2_reg <= sy1_reg;
         sy3_reg <= {sy2_reg[43], sy2_reg[1], sy2_reg[0]};
      end
   end

   // bus handshakes, answer two cycles on
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `DCX_RESP_OK;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= `DCX_RESP_OK;
         s_axi_rdata   <= 32'h0000_0000;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready  <= wr_go;
         if (s_axi_awready) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wa_ok ? `DCX_RESP_OK : `DCX_RESP_ERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= rd_go;
         if (s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `DCX_RESP_OK;
            s_axi_rdata  <= 32'h0000_0000;
            case (s_axi_araddr)
               `DCX_TASK:   s_axi_rdata[15:0] <= task_reg;
               `DCX_CFGA:   s_axi_rdata[15:0] <= cfga_reg;
               `DCX_CFGB:   s_axi_rdata[15:0] <= cfgb_reg;
               `DCX_ADDR:   s_axi_rdata[15:0] <= addr_reg[15:0];
               `DCX_MODULE: s_axi_rdata[3:0]  <= addr_reg[20:17];
               `DCX_RANGE:  s_axi_rdata[15:0] <= range_reg;
               `DCX_ST1:    s_axi_rdata[15:0] <= st1_reg;
               `DCX_ST2:    s_axi_rdata[15:0] <= st2_reg;
               `DCX_CTRL:   s_axi_rdata <= 32'h0000_0000;
               `DCX_ILVL:   s_axi_rdata[5:0]  <= ilvl_reg;
               `DCX_EPTR:   s_axi_rdata[8:0]  <= eptr_reg;
               `DCX_EDATA:  s_axi_rdata[7:0]  <= elog_mem[eptr_reg];
               `DCX_STATE:  s_axi_rdata[5:0]  <= state_reg;
               default:     s_axi_rresp <= `DCX_RESP_ERR;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // gates follow the state, so they lag the transfer by one cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         disk_wr_gate_reg   <= 1'b0;
         disk_rd_gate_reg   <= 1'b0;
         disk_check_gen_reg <= 1'b1;
      end else begin
         disk_wr_gate_reg   <= state_reg[2] & ~rd_mode;
         disk_rd_gate_reg   <= state_reg[2] & rd_mode;
         disk_check_gen_reg <= ~diag;
      end
   end

   // buffer array writes, no reset needed on data
   always @(posedge aclk) begin
      if (state_reg[3] & have_reg) begin
         if (task_reg[0])
            wbuf_a[wptr_reg[11:0]] <= buf_reg;
         else
            wbuf_b[wptr_reg[11:0]] <= buf_reg;
      end
      if (state_reg[2] & elog_reg & byte_ev)
         elog_mem[{esec_reg, cnt_reg[7:0]}] <= rd_byte;
      else if (wr_en & (wa == `DCX_EDATA) & idle)
         elog_mem[eptr_reg] <= wd[7:0];
   end

   // register file and command sequencer
   always @(posedge aclk) begin
      irq_reg        <= 1'b0;
      disk_recal_reg <= 1'b0;
      if (!aresetn || do_init) begin
         // initialize acts like power-up, quietly dropping any task
         task_reg         <= 16'h0000;
         cfga_reg         <= 16'h0000;
         cfgb_reg         <= 16'h0000;
         addr_reg         <= 21'h00_0000;
         range_reg        <= 16'h0000;
         st1_reg          <= 16'h0000;
         st2_reg          <= 16'h0000;
         ilvl_reg         <= 6'h00;
         eptr_reg         <= 9'h000;
         cnt_reg          <= 9'h000;
         idx_reg          <= 1'b0;
         herr_reg         <= 1'b0;
         buf_reg          <= 8'h00;
         have_reg         <= 1'b0;
         wlen_reg         <= 13'h0000;
         wptr_reg         <= 13'h0000;
         mem_req_reg      <= 1'b0;
         mem_we_reg       <= 1'b0;
         mem_addr_reg     <= 21'h00_0000;
         mem_wdata_reg    <= 8'h00;
         disk_wr_byte_reg <= 8'h00;
         esec_reg         <= 1'b0;
         elog_reg         <= 1'b1;
         state_reg        <= S_SRCH;
         disk_recal_reg   <= aresetn;
      end else if (do_abort) begin
         // keep status, address and range as they stand
         state_reg   <= S_IDLE;
         mem_req_reg <= 1'b0;
         have_reg    <= 1'b0;
         elog_reg    <= 1'b0;
         irq_reg     <= (ilvl_reg != 6'h00);
      end else begin
         // software writes, only while idle except control orders
         if (wr_en & idle) begin
            case (wa)
               `DCX_CFGA:  cfga_reg  <= wd[15:0];
               `DCX_CFGB:  cfgb_reg  <= wd[15:0];
               `DCX_ADDR:  addr_reg  <= wd[20:0];
               `DCX_RANGE: range_reg <= wd[15:0];
               `DCX_ILVL:  ilvl_reg  <= wd[5:0];
               `DCX_EPTR:  eptr_reg  <= wd[8:0];
               `DCX_EDATA: eptr_reg  <= eptr_reg + 9'h001;
               default: ;
            endcase
         end
         // memory handshake completion
         if (mem_req_reg & mem_ack) begin
            mem_req_reg <= 1'b0;
            addr_reg    <= addr_reg + 21'h00_0001;
            if (!mem_we_reg) begin
               buf_reg  <= mem_rdata;
               have_reg <= 1'b1;
            end
         end
         case (state_reg)
            S_IDLE: begin
               if (wr_en & (wa == `DCX_TASK)) begin
                  // a new task word clears detailed status
                  task_reg <= wd[15:0];
                  st1_reg  <= 16'h0000;
                  st2_reg  <= 16'h0000;
                  idx_reg  <= 1'b0;
                  herr_reg <= 1'b0;
                  cnt_reg  <= 9'h000;
                  wptr_reg <= 13'h0000;
                  have_reg <= 1'b0;
                  case (wd[15:12])
                     `DCX_CMD_WR, `DCX_CMD_DWR, `DCX_CMD_DRD: begin
                        if (range_reg == 16'h0000)
                           state_reg <= S_DONE;
                        else
                           state_reg <= S_SRCH;
                     end
                     `DCX_CMD_WRW, `DCX_CMD_WRR: begin
                        if ((range_reg == 16'h0000) || (range_reg > WRAP_MAX)) begin
                           st1_reg[`DCX_ST1_WRAP] <= 1'b1;
                           state_reg <= S_DONE;
                        end else if (wd[15:12] == `DCX_CMD_WRW) begin
                           wlen_reg  <= range_reg[12:0];
                           state_reg <= S_WRPW;
                        end else begin
                           state_reg <= S_WRPR;
                        end
                     end
                     `DCX_CMD_RCL: begin
                        disk_recal_reg <= 1'b1;
                        state_reg      <= S_DONE;
                     end
                     default: begin
                        st1_reg[`DCX_ST1_PGERR] <= 1'b1;
                        state_reg <= S_DONE;
                     end
                  endcase
               end
            end
            S_SRCH: begin
               if (id_ev) begin
                  if (id_crc) begin
                     // a bad id counts as a miscompare
                     herr_reg <= 1'b1;
                     if (!elog_reg)
                        st1_reg[`DCX_ST1_RDERR] <= 1'b1;
                  end else if (dcx_match(id_val, tgt)) begin
                     cnt_reg   <= 9'h000;
                     state_reg <= S_XFER;
                     if (herr_reg & !elog_reg) begin
                        st1_reg[`DCX_ST1_RDERR] <= 1'b0;
                        st1_reg[`DCX_ST1_RECOV] <= 1'b1;
                        st2_reg[`DCX_ST2_RECOV] <= 1'b1;
                     end
                  end
               end else if (idx_ev) begin
                  if (idx_reg) begin
                     // second index without a hit: give up
                     idx_reg <= 1'b0;
                     if (elog_reg) begin
                        elog_reg  <= 1'b0;
                        state_reg <= S_IDLE;
                     end else begin
                        st1_reg[`DCX_ST1_UNSUCC] <= 1'b1;
                        state_reg <= S_DONE;
                     end
                  end else begin
                     idx_reg <= 1'b1;
                  end
               end
            end
            S_XFER: begin
               // fetch ahead for writes so a byte is ready at the slot
               if (!rd_mode & !have_reg & !mem_req_reg & (range_reg != 16'h0000)) begin
                  mem_req_reg  <= 1'b1;
                  mem_we_reg   <= 1'b0;
                  mem_addr_reg <= addr_reg;
               end
               if (byte_ev) begin
                  cnt_reg <= cnt_reg + 9'h001;
                  if (rd_mode) begin
                     if (!elog_reg & (range_reg != 16'h0000)) begin
                        // no correction applied, check bytes pass as data
                        mem_req_reg   <= 1'b1;
                        mem_we_reg    <= 1'b1;
                        mem_addr_reg  <= addr_reg;
                        mem_wdata_reg <= rd_byte;
                        range_reg     <= range_reg - 16'h0001;
                     end
                  end else if (range_reg != 16'h0000) begin
                     disk_wr_byte_reg <= buf_reg;
                     have_reg         <= 1'b0;
                     range_reg        <= range_reg - 16'h0001;
                  end else begin
                     disk_wr_byte_reg <= 8'h00;
                  end
                  if (cnt_reg == last_b) begin
                     idx_reg  <= 1'b0;
                     herr_reg <= 1'b0;
                     if (elog_reg) begin
                        esec_reg  <= 1'b1;
                        elog_reg  <= ~esec_reg;
                        state_reg <= esec_reg ? S_IDLE : S_SRCH;
                     end else begin
                        cfgb_reg[7:0] <= cfgb_reg[7:0] + 8'h01;
                        if (!diag & (range_reg > 16'h0001))
                           state_reg <= S_SRCH;
                        else
                           state_reg <= S_DONE;
                     end
                  end
               end
            end
            S_WRPW: begin
               if (have_reg) begin
                  have_reg  <= 1'b0;
                  wptr_reg  <= wptr_reg + 13'h0001;
                  range_reg <= range_reg - 16'h0001;
                  if (wptr_reg + 13'h0001 == wlen_reg)
                     state_reg <= S_DONE;
               end else if (!mem_req_reg) begin
                  mem_req_reg  <= 1'b1;
                  mem_we_reg   <= 1'b0;
                  mem_addr_reg <= addr_reg;
               end
            end
            S_WRPR: begin
               if (mem_req_reg & mem_ack) begin
                  wptr_reg  <= wptr_reg + 13'h0001;
                  range_reg <= range_reg - 16'h0001;
                  if ((wptr_reg + 13'h0001 == wlen_reg) || (range_reg == 16'h0001))
                     state_reg <= S_DONE;
               end else if (!mem_req_reg) begin
                  mem_req_reg   <= 1'b1;
                  mem_we_reg    <= 1'b1;
                  mem_addr_reg  <= addr_reg;
                  mem_wdata_reg <= wrap_rd;
               end
            end
            S_DONE: begin
               // a write ending on a high-order byte skips the low byte
               if (!mem_req_reg) begin
                  if (((cmd[3:0] == `DCX_CMD_WR) | (cmd[3:0] == `DCX_CMD_DWR))
                      & addr_reg[0])
                     addr_reg <= addr_reg + 21'h00_0001;
                  irq_reg   <= (ilvl_reg != 6'h00);
                  have_reg  <= 1'b0;
                  state_reg <= S_IDLE;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

endmodule // dcx_channel

// File: core/dcx_regs.vh
`ifndef DCX_REGS_VH
`define DCX_REGS_VH
// register byte offsets
`define DCX_TASK    8'h00
`define DCX_CFGA    8'h04
`define DCX_CFGB    8'h08
`define DCX_ADDR    8'h0C
`define DCX_MODULE  8'h10
`define DCX_RANGE   8'h14
`define DCX_ST1     8'h18
`define DCX_ST2     8'h1C
`define DCX_CTRL    8'h20
`define DCX_ILVL    8'h24
`define DCX_EPTR    8'h28
`define DCX_EDATA   8'h2C
`define DCX_STATE   8'h30
// command codes in task bits 15:12
`define DCX_CMD_WR   4'h1
`define DCX_CMD_DWR  4'h2
`define DCX_CMD_DRD  4'h3
`define DCX_CMD_WRW  4'h4
`define DCX_CMD_WRR  4'h5
`define DCX_CMD_RCL  4'h6
// status bit positions (doc bit n sits at 15-n)
`define DCX_ST1_RDERR  11
`define DCX_ST1_PGERR  10
`define DCX_ST1_UNSUCC 8
`define DCX_ST1_RECOV  6
`define DCX_ST1_WRAP   4
`define DCX_ST2_RECOV  6
// control order bits
`define DCX_CTRL_INIT  0
`define DCX_CTRL_ABORT 1
// sizes
`define DCX_SECT_LEN  9'h100
`define DCX_DIAG_LEN  9'h107
`define DCX_WRAP_MAX  16'h1000
`define DCX_ELOG_CYL  16'h0000
`define DCX_RESP_OK   2'b00
`define DCX_RESP_ERR  2'b10
`endif

// File: test/dcx_channel_monitor.sv
`timescale 1ns/10ps
module dcx_channel_monitor (
   // clock and reset
   input wire        aclk,
   input wire        aresetn,
   // bus handshake
   input wire        s_axi_awready,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata,
   // memory port and drive side
   input wire        irq_reg,
   input wire        mem_req_reg,
   input wire        mem_ack,
   input wire [20:0] mem_addr_reg,
   input wire        disk_wr_gate_reg,
   input wire        disk_rd_gate_reg,
   input wire        disk_recal_reg
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // bus timing
   AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready long");
   AST_W_PAIR: assert property (s_axi_awready == s_axi_wready)
      else $error("wready apart");
   AST_B_NEXT: assert property (s_axi_awready |=> s_axi_bvalid)
      else $error("no bvalid");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("rdata not held");
   // request held until ack, unless a control order cuts it
   AST_MEM_HOLD: assert property (mem_req_reg && !mem_ack && !s_axi_awready |=> mem_req_reg && $stable(mem_addr_reg))
      else $error("request moved");
   AST_IRQ_PULSE: assert property (irq_reg |=> !irq_reg)
      else $error("irq long");
   AST_GATE_EXCL: assert property (!(disk_wr_gate_reg && disk_rd_gate_reg))
      else $error("both gates");
   AST_RECAL_PULSE: assert property (disk_recal_reg |=> !disk_recal_reg)
      else $error("recal long");
   CV_IRQ: cover property (irq_reg);
   CV_WRITE: cover property (disk_wr_gate_reg);
   CV_RECAL: cover property (disk_recal_reg);
endmodule // dcx_channel_monitor

// File: test/dcx_far_model.sv
`timescale 1ns/10ps
module dcx_far_model (
   // memory side
   input wire aclk, mem_req_reg, mem_we_reg,
   input wire [20:0] mem_addr_reg,
   input wire [7:0] mem_wdata_reg,
   output reg [7:0] mem_rdata,
   output reg mem_ack,
   // drive side
   output reg disk_index, disk_id_tgl, disk_id_crc_err, disk_byte_tgl,
   output reg [31:0] disk_id,
   output reg [7:0] disk_rd_byte,
   input wire disk_wr_gate_reg,
   input wire [7:0] disk_wr_byte_reg
);
   reg [7:0] mem [0:4095];
   integer   nz_cnt, s, b;
   // pattern differs per page so copies can be told apart
   initial begin
      for (s = 0; s < 4096; s = s + 1) mem[s] = s[7:0] ^ {s[11:8], s[11:8]};
      {mem_ack, disk_index, disk_id_tgl, disk_id_crc_err, disk_byte_tgl} = 5'h00;
      mem_rdata = 8'h00;
      disk_id = 32'h0000_0000;
      disk_rd_byte = 8'h00;
      nz_cnt = 0;
   end
   // ack one cycle after request; idle data toggles, never holds
   always @(posedge aclk) begin
      mem_ack <= mem_req_reg && !mem_ack;
      if (mem_req_reg && !mem_ack) begin
         if (mem_we_reg) mem[mem_addr_reg[11:0]] <= mem_wdata_reg;
         mem_rdata <= mem[mem_addr_reg[11:0]];
      end else mem_rdata <= ~mem_rdata;
   end
   // track of four sectors, cylinder 0 head 0; nonzero written bytes counted
   initial forever begin
      disk_index <= 1'b1;
      repeat (4) @(posedge aclk);
      disk_index <= 1'b0;
      for (s = 0; s < 4; s = s + 1) begin
         disk_id <= {24'h00_0000, s[7:0]};
         repeat (4) @(posedge aclk);
         disk_id_tgl <= ~disk_id_tgl;
         repeat (8) @(posedge aclk);
         for (b = 0; b < 263; b = b + 1) begin
            disk_rd_byte <= b[7:0];
            repeat (4) @(posedge aclk);
            if (disk_wr_gate_reg && disk_wr_byte_reg !== 8'h00) nz_cnt = nz_cnt + 1;
            disk_byte_tgl <= ~disk_byte_tgl;
         end
      end
   end
endmodule // dcx_far_model

// File: test/disk_channel_command_exec_tb.sv
`timescale 1ns/10ps
`include "dcx_regs.vh"
module disk_channel_command_exec_tb;
   // bus and pins
   reg         aclk, aresetn, awv, wv, bready, arv, rready;
   reg  [7:0]  awa, ara;
   reg  [31:0] wd, got;
   reg  [1:0]  resp;
   wire        awr, wrd, bv, arr, rv, irq, mreq, mwe, mack, idx, itg, icrc, btg, wg, recal;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata, did;
   wire [20:0] maddr;
   wire [7:0]  mwd, mrd, rdb, wrb;
   reg  [79:0] rows [0:5];
   integer     err_total, total_checks, irq_cnt, rc_cnt, i, n, m;
   dcx_channel uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready), .irq_reg(irq),
      .mem_req_reg(mreq), .mem_we_reg(mwe), .mem_addr_reg(maddr), .mem_wdata_reg(mwd),
      .mem_rdata(mrd), .mem_ack(mack), .disk_index(idx), .disk_id_tgl(itg),
      .disk_id_crc_err(icrc), .disk_id(did), .disk_byte_tgl(btg), .disk_rd_byte(rdb),
      .disk_wr_gate_reg(wg), .disk_rd_gate_reg(), .disk_check_gen_reg(),
      .disk_wr_byte_reg(wrb), .disk_recal_reg(recal));
   dcx_far_model pm (.aclk(aclk), .mem_req_reg(mreq), .mem_we_reg(mwe), .mem_addr_reg(maddr),
      .mem_wdata_reg(mwd), .mem_rdata(mrd), .mem_ack(mack), .disk_index(idx),
      .disk_id_tgl(itg), .disk_id_crc_err(icrc), .disk_byte_tgl(btg), .disk_id(did),
      .disk_rd_byte(rdb), .disk_wr_gate_reg(wg), .disk_wr_byte_reg(wrb));
   task chk(input [31:0] g, input [31:0] e);
      begin
         total_checks = total_checks + 1;
         if (g !== e) begin
            err_total = err_total + 1;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
         end
      end
   endtask
   // both write channels offered together, released when taken
   task wr(input [7:0] a, input [31:0] d);
      begin
         awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
         @(posedge aclk);
         while (!awr) @(posedge aclk);
         awv <= 1'b0; wv <= 1'b0; bready <= 1'b1;
         @(posedge aclk);
         while (!bv) @(posedge aclk);
         bready <= 1'b0; resp = bresp;
      end
   endtask
   task rd(input [7:0] a);
      begin
         ara <= a; arv <= 1'b1;
         @(posedge aclk);
         while (!arr) @(posedge aclk);
         arv <= 1'b0; rready <= 1'b1;
         @(posedge aclk);
         while (!rv) @(posedge aclk);
         rready <= 1'b0; got = rdata; resp = rresp;
      end
   endtask
   // irq pulses on the same edge that enters idle
   task wait_idle;
      begin
         got = 32'h0000_0000;
         while (got !== 32'h0000_0001) rd(`DCX_STATE);
         repeat (4) @(posedge aclk);
      end
   endtask
   task complete_run;
      begin
         if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // event counters for pulses
   always @(posedge aclk) begin
      if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
      if (recal === 1'b1) rc_cnt <= rc_cnt + 1;
   end
   initial begin
      repeat (90000) @(posedge aclk);
      err_total = err_total + 1;
      complete_run;
   end
   initial begin
      {aresetn, awv, wv, bready, arv, rready} = 6'h00;
      {awa, ara, wd} = 48'h0000_0000_0000;
      {err_total, total_checks, irq_cnt, rc_cnt} = 128'h0;
      rows[0] = {`DCX_CFGA, 32'hffff_1234, `DCX_CFGA, 32'h0000_1234};
      rows[1] = {`DCX_CFGB, 32'h0000_0302, `DCX_CFGB, 32'h0000_0302};
      rows[2] = {`DCX_ADDR, 32'h001a_bcde, `DCX_ADDR, 32'h0000_bcde};
      rows[3] = {`DCX_ADDR, 32'h001a_bcde, `DCX_MODULE, 32'h0000_000d};
      rows[4] = {`DCX_RANGE, 32'h0000_0107, `DCX_RANGE, 32'h0000_0107};
      rows[5] = {`DCX_ILVL, 32'h0000_00ff, `DCX_ILVL, 32'h0000_003f};
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      wait_idle;
      rd(`DCX_ILVL); chk(got, 32'h0000_0000);
      for (i = 0; i < 6; i = i + 1) begin
         wr(rows[i][79:72], rows[i][71:40]);
         rd(rows[i][39:32]); chk(got, rows[i][31:0]);
      end
      rd(8'h3c); chk(resp, 2'b10);
      wr(8'h3c, 32'h0000_0000); chk(resp, 2'b10);
      wr(`DCX_ILVL, 32'h0000_0001); wr(`DCX_CFGA, 32'h0000_0000);
      wr(`DCX_CFGB, 32'h0000_0002); wr(`DCX_RANGE, 32'h0000_0000);
      n = irq_cnt; m = pm.nz_cnt;
      wr(`DCX_TASK, 32'h0000_1000); wait_idle;
      chk(irq_cnt - n, 1);
      chk(pm.nz_cnt - m, 0);
      rd(`DCX_CFGB); chk(got, 32'h0000_0002);
      wr(`DCX_ADDR, 32'h0000_0010); wr(`DCX_RANGE, 32'h0000_0001);
      wr(`DCX_TASK, 32'h0000_1000); wait_idle;
      rd(`DCX_CFGB); chk(got, 32'h0000_0003);
      chk(pm.nz_cnt - m, 1);
      rd(`DCX_RANGE); chk(got, 32'h0000_0000);
      wr(`DCX_CFGB, 32'h0000_0009); wr(`DCX_RANGE, 32'h0000_0004);
      wr(`DCX_TASK, 32'h0000_1000); wait_idle;
      rd(`DCX_ST1); chk(got[`DCX_ST1_UNSUCC], 1);
      rd(`DCX_RANGE); chk(got, 32'h0000_0004);
      for (i = 0; i < 2; i = i + 1) begin
         wr(`DCX_RANGE, i * 4097); wr(`DCX_TASK, 32'h0000_4000); wait_idle;
         rd(`DCX_ST1); chk(got[`DCX_ST1_WRAP], 1);
      end
      // both buffers, back to another page
      for (i = 0; i < 2; i = i + 1) begin
         wr(`DCX_ADDR, 32'h0000_0100); wr(`DCX_RANGE, 32'h0000_0003);
         wr(`DCX_TASK, 32'h0000_4000 | i); wait_idle;
         wr(`DCX_ADDR, 32'h0000_0200 + i * 16); wr(`DCX_RANGE, 32'h0000_0003);
         wr(`DCX_TASK, 32'h0000_5000 | i); wait_idle;
         for (n = 0; n < 3; n = n + 1) chk(pm.mem[512 + i * 16 + n], n ^ 32'h0000_0011);
      end
      wr(`DCX_ADDR, 32'h0000_0000); wr(`DCX_RANGE, 32'h0000_1000);
      n = irq_cnt;
      wr(`DCX_TASK, 32'h0000_4000); repeat (40) @(posedge aclk);
      wr(`DCX_CTRL, 32'h0000_0002); wait_idle;
      chk(irq_cnt - n, 1);
      rd(`DCX_RANGE); chk(got > 0 && got < 4096, 1);
      wr(`DCX_ILVL, 32'h0000_0005);
      n = rc_cnt; m = irq_cnt;
      wr(`DCX_CTRL, 32'h0000_0001); wait_idle;
      chk(rc_cnt - n, 1);
      chk(irq_cnt - m, 0);
      rd(`DCX_ILVL); chk(got, 32'h0000_0000);
      complete_run;
   end
endmodule // disk_channel_command_exec_tb
bind dcx_channel dcx_channel_monitor mon (.*);
